// >>> lcd_port_setup.sv
// Purpose: APB register file and decoded setup for two display panel ports
// Assumes: APB4 slave, zero wait states; panel type and frame pulses come from this clock
// Notes: Decoded outputs follow a register write by two cycles, P2_AREA_SMALL_OUT by three
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module lcd_port_setup
   import lcd_port_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Panel type select and frame control
   input wire logic [1:0] PANEL_TYPE_IN,
   input wire logic P1_START_IN,
   input wire logic P1_DONE_IN,
   input wire logic P2_START_IN,
   input wire logic P2_DONE_IN,
   // Frame sync pins
   input wire logic PORT1_FRAME_SYNC_IN,
   input wire logic PORT2_FRAME_SYNC_IN,
   // Frame gating
   output logic P1_GO_OUT,
   output logic P1_ABORT_OUT,
   output logic P1_BUSY_OUT,
   output logic P2_GO_OUT,
   output logic P2_ABORT_OUT,
   output logic P2_BUSY_OUT,
   // First port parallel setup
   output logic P1_TYPE68_OUT,
   output logic P1_FMT_ACTIVE_OUT,
   output logic [4:0] P1_BUS_WIDTH_OUT,
   output logic [1:0] P1_CYCLES_OUT,
   output logic [1:0] P1_PIXELS_OUT,
   output logic P1_FMT_RSVD_OUT,
   // Second port parallel setup
   output logic P2_TYPE68_OUT,
   output logic [4:0] P2_BUS_WIDTH_OUT,
   output logic [1:0] P2_CYCLES_OUT,
   output logic [1:0] P2_PIXELS_OUT,
   output logic P2_FMT_RSVD_OUT,
   // Second port display size
   output logic [10:0] P2_WIDTH_PIX_OUT,
   output logic [10:0] P2_HEIGHT_OUT,
   output logic P2_AREA_SMALL_OUT,
   // Second port serial setup
   output logic P2_SER_3WIRE_OUT,
   output logic [3:0] P2_SER_WORD_BITS_OUT,
   output logic P2_SER_LSB_FIRST_OUT,
   output logic [1:0] P2_SER_XFERS_OUT,
   output logic [1:0] P2_SER_PIXELS_OUT,
   output logic P2_SER_RSVD_OUT,
   output logic P2_SCLK_IDLE_HIGH_OUT,
   output logic P2_SCLK_CHANGE_RISE_OUT
);

   // Reset release
   logic [1:0] rst_pipe;
   logic rst_n;

   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   default clocking main_cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!rst_n);

   // Registers
   logic [15:0] p1_par;
   logic [15:0] p2_wid;
   logic [15:0] p2_hgt;
   logic [15:0] p2_ser;
   logic [15:0] p2_par;
   logic [31:0] prdata;

   // APB decode
   wire setup_phase = PSEL_IN & ~PENABLE_IN;
   wire access_phase = PSEL_IN & PENABLE_IN;
   wire hit_p1_par = (PADDR_IN == {IDX_P1_PAR, 2'b00});
   wire hit_p2_wid = (PADDR_IN == {IDX_P2_WID, 2'b00});
   wire hit_p2_hgt = (PADDR_IN == {IDX_P2_HGT, 2'b00});
   wire hit_p2_ser = (PADDR_IN == {IDX_P2_SER, 2'b00});
   wire hit_p2_par = (PADDR_IN == {IDX_P2_PAR, 2'b00});
   wire hit_status = (PADDR_IN == {IDX_STATUS, 2'b00});
   wire mapped = hit_p1_par | hit_p2_wid | hit_p2_hgt | hit_p2_ser | hit_p2_par | hit_status;
   wire wr_en = access_phase & PWRITE_IN & mapped;
   wire [15:0] lane_mask = {{8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};

   // Merge written lanes into the old value; unused bits stay zero
   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] data,
                                          input logic [15:0] lanes, input logic [15:0] mask);
      return ((old & ~lanes) | (data & lanes)) & mask;
   endfunction

   wire [15:0] wdata = PWDATA_IN[15:0];

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         p1_par <= RST_P1_PAR;
         p2_wid <= RST_WID;
         p2_hgt <= RST_HGT;
         p2_ser <= RST_SER;
         p2_par <= RST_P2_PAR; // R16
      end else if (wr_en) begin
         if (hit_p1_par) p1_par <= wmerge(p1_par, wdata, lane_mask, MASK_P1_PAR); // R18
         if (hit_p2_wid) p2_wid <= wmerge(p2_wid, wdata, lane_mask, MASK_WID); // R18
         if (hit_p2_hgt) p2_hgt <= wmerge(p2_hgt, wdata, lane_mask, MASK_HGT); // R18
         if (hit_p2_ser) p2_ser <= wmerge(p2_ser, wdata, lane_mask, MASK_SER); // R18
         if (hit_p2_par) p2_par <= wmerge(p2_par, wdata, lane_mask, MASK_P2_PAR); // R16 R18
      end
   end

   // Frame sync edges and gating
   logic p1_fall;
   logic p2_fall;

   fsync_edge u_p1_sync (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(rst_n),
      .pin_in(PORT1_FRAME_SYNC_IN),
      .fall_out(p1_fall)
   );

   fsync_edge u_p2_sync (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(rst_n),
      .pin_in(PORT2_FRAME_SYNC_IN),
      .fall_out(p2_fall)
   );

   // RGB panels ignore the parallel format and sync enable of the first port
   wire p1_fmt_active = (PANEL_TYPE_IN != PANEL_RGB_A) && (PANEL_TYPE_IN != PANEL_RGB_B); // R4
   wire p1_sync_en = p1_par[BIT_SYNC_EN] & p1_fmt_active;
   wire p2_sync_en = p2_par[BIT_SYNC_EN]; // R12

   frame_gate u_p1_gate (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(rst_n),
      .sync_en_in(p1_sync_en),
      .start_in(P1_START_IN),
      .done_in(P1_DONE_IN),
      .sync_fall_in(p1_fall),
      .go_out(P1_GO_OUT),
      .abort_out(P1_ABORT_OUT),
      .busy_out(P1_BUSY_OUT)
   );

   frame_gate u_p2_gate (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(rst_n),
      .sync_en_in(p2_sync_en),
      .start_in(P2_START_IN),
      .done_in(P2_DONE_IN),
      .sync_fall_in(p2_fall),
      .go_out(P2_GO_OUT),
      .abort_out(P2_ABORT_OUT),
      .busy_out(P2_BUSY_OUT)
   );

   // Decoded setup
   wire fmt_info_t next_p1_info = p1_fmt_active ? decode_par_fmt(p1_par[FMT_LSB +: 3]) : '0; // R2 R3 R4
   wire fmt_info_t next_p2_info = decode_par_fmt(p2_par[FMT_LSB +: 3]); // R2 R3
   wire fmt_info_t next_ser_info = decode_ser_fmt(p2_ser[SER_FMT_LSB +: 2]); // R10
   wire [10:0] next_width = {1'b0, p2_wid[WID_W-1:0], 1'b0} + 11'h002; // R5
   wire [10:0] next_height = {1'b0, p2_hgt[HGT_W-1:0]} + 11'h001; // R6
   wire [21:0] area = P2_WIDTH_PIX_OUT * P2_HEIGHT_OUT;
   wire next_area_small = (area < MIN_AREA); // R7
   wire next_idle_high = p2_ser[BIT_SER_POL]; // R11
   wire next_change_rise = p2_ser[BIT_SER_PHASE] ^ p2_ser[BIT_SER_POL]; // R11
   wire [3:0] next_word_bits = p2_ser[BIT_SER_3WIRE] ? 4'h9 : 4'h8; // R8

   fmt_info_t p1_info;
   fmt_info_t p2_info;
   fmt_info_t ser_info;

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         p1_info <= '0;
         p2_info <= '0;
         ser_info <= '0;
         P1_TYPE68_OUT <= 1'b0;
         P1_FMT_ACTIVE_OUT <= 1'b0;
         P2_TYPE68_OUT <= 1'b0;
         P2_WIDTH_PIX_OUT <= 11'h000;
         P2_HEIGHT_OUT <= 11'h000;
         P2_AREA_SMALL_OUT <= 1'b0;
         P2_SER_3WIRE_OUT <= 1'b0;
         P2_SER_WORD_BITS_OUT <= 4'h8;
         P2_SER_LSB_FIRST_OUT <= 1'b0;
         P2_SCLK_IDLE_HIGH_OUT <= 1'b0;
         P2_SCLK_CHANGE_RISE_OUT <= 1'b0;
      end else begin
         p1_info <= next_p1_info;
         p2_info <= next_p2_info;
         ser_info <= next_ser_info;
         P1_TYPE68_OUT <= p1_par[BIT_TYPE68]; // R1
         P1_FMT_ACTIVE_OUT <= p1_fmt_active;
         P2_TYPE68_OUT <= p2_par[BIT_TYPE68]; // R15
         P2_WIDTH_PIX_OUT <= next_width;
         P2_HEIGHT_OUT <= next_height;
         P2_AREA_SMALL_OUT <= next_area_small;
         P2_SER_3WIRE_OUT <= p2_ser[BIT_SER_3WIRE]; // R8
         P2_SER_WORD_BITS_OUT <= next_word_bits;
         P2_SER_LSB_FIRST_OUT <= p2_ser[BIT_SER_LSB]; // R9
         P2_SCLK_IDLE_HIGH_OUT <= next_idle_high;
         P2_SCLK_CHANGE_RISE_OUT <= next_change_rise;
      end
   end

   assign P1_BUS_WIDTH_OUT = p1_info.bus_width;
   assign P1_CYCLES_OUT = p1_info.cycles;
   assign P1_PIXELS_OUT = p1_info.pixels;
   assign P1_FMT_RSVD_OUT = p1_info.reserved;
   assign P2_BUS_WIDTH_OUT = p2_info.bus_width;
   assign P2_CYCLES_OUT = p2_info.cycles;
   assign P2_PIXELS_OUT = p2_info.pixels;
   assign P2_FMT_RSVD_OUT = p2_info.reserved;
   assign P2_SER_XFERS_OUT = ser_info.cycles;
   assign P2_SER_PIXELS_OUT = ser_info.pixels;
   assign P2_SER_RSVD_OUT = ser_info.reserved;

   // Read path, captured in the setup cycle so data is ready in the access cycle
   wire [15:0] status_word = {13'h0000, P2_AREA_SMALL_OUT, P2_BUSY_OUT, P1_BUSY_OUT};
   wire [15:0] rd_mux = ({16{hit_p1_par}} & p1_par) | ({16{hit_p2_wid}} & p2_wid) |
                        ({16{hit_p2_hgt}} & p2_hgt) | ({16{hit_p2_ser}} & p2_ser) |
                        ({16{hit_p2_par}} & p2_par) | ({16{hit_status}} & status_word);

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !PWRITE_IN) begin
         prdata <= {16'h0000, rd_mux}; // R18
      end
   end

   assign PRDATA_OUT = prdata;
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = access_phase & ~mapped;

   // Checks
   a_p1_type_wr: assert property (
      (wr_en && hit_p1_par && PSTRB_IN[0] && PWDATA_IN[6]) |=> ##1 P1_TYPE68_OUT) // R1
      else $error("first port bus style not set by write");
   a_p2_888_narrow: assert property (
      (p2_par[2:0] == 3'h3) |=> P2_BUS_WIDTH_OUT == 5'h08 && P2_CYCLES_OUT == 2'h3 && P2_PIXELS_OUT == 2'h1) // R2
      else $error("8:8:8 narrow packing wrong");
   a_p2_666_wide: assert property (
      (p2_par[2:0] == 3'h7) |=> P2_BUS_WIDTH_OUT == 5'h12 && P2_CYCLES_OUT == 2'h1 && !P2_FMT_RSVD_OUT) // R3
      else $error("6:6:6 wide packing wrong");
   a_p2_fmt_rsvd: assert property (
      (p2_par[2:0] == 3'h4) |=> P2_FMT_RSVD_OUT && P2_BUS_WIDTH_OUT == 5'h00) // R3
      else $error("reserved format not flagged");
   a_rgb_ignores: assert property (
      (PANEL_TYPE_IN == PANEL_RGB_A || PANEL_TYPE_IN == PANEL_RGB_B) |=>
      !P1_FMT_ACTIVE_OUT && P1_BUS_WIDTH_OUT == 5'h00 && P1_CYCLES_OUT == 2'h0) // R4
      else $error("format applied to RGB panel");
   a_width_pixels: assert property (
      (p2_wid[8:0] == 9'h13F) |=> P2_WIDTH_PIX_OUT == 11'h280) // R5
      else $error("width in pixels wrong");
   a_height_lines: assert property (
      (p2_hgt[9:0] == 10'h3FF) |=> P2_HEIGHT_OUT == 11'h400) // R6
      else $error("height in lines wrong");
   a_serial_style: assert property (
      p2_ser[5] |=> P2_SER_3WIRE_OUT && P2_SER_WORD_BITS_OUT == 4'h9) // R8
      else $error("three-wire link not selected");
   a_serial_order: assert property (
      $rose(p2_ser[4]) |=> P2_SER_LSB_FIRST_OUT) // R9
      else $error("shift order not updated");
   a_serial_444: assert property (
      (p2_ser[3:2] == 2'h1) |=> P2_SER_XFERS_OUT == 2'h3 && P2_SER_PIXELS_OUT == 2'h2) // R10
      else $error("serial 4:4:4 packing wrong");
   a_sclk_mode01: assert property (
      (p2_ser[1:0] == 2'h1) |=> P2_SCLK_IDLE_HIGH_OUT && P2_SCLK_CHANGE_RISE_OUT) // R11
      else $error("clock mode 01 wrong");
   a_sclk_mode11: assert property (
      (p2_ser[1:0] == 2'h3) |=> P2_SCLK_IDLE_HIGH_OUT && !P2_SCLK_CHANGE_RISE_OUT) // R11
      else $error("clock mode 11 wrong");
   a_p2_type_wr: assert property (
      (wr_en && hit_p2_par && PSTRB_IN[0] && !PWDATA_IN[6]) |=> ##1 !P2_TYPE68_OUT) // R15
      else $error("second port bus style not cleared by write");
   a_p2par_mask: assert property (
      (wr_en && hit_p2_par && PSTRB_IN[1] && PSTRB_IN[0]) |=> p2_par == ($past(PWDATA_IN[15:0]) & MASK_P2_PAR)) // R16
      else $error("second port parallel write not masked");
   a_unused_zero: assert property (
      (setup_phase && !PWRITE_IN && hit_p2_ser) |=> PRDATA_OUT[31:6] == 26'h0000000) // R18
      else $error("unused serial bits read nonzero");

endmodule

`default_nettype wire

// >>> lcd_port_pkg.sv
// Purpose: Constants, register map and format decoding for the panel port setup block
// Assumes: APB with 32-bit data; each 16-bit register sits in the low half of one word
// Notes: Register indices are multiplied by four to form byte addresses
// How it works
// R1 - First port bit 6 picks bus style: 0 is 80-type, 1 is 68-type.
// R2 - Format 000 332 one cycle, 001 444 three per two, 011 888 three per pixel.
// R3 - Wide formats: 010 888 on 16, 101 444, 110 565, 111 666 on 18; 100 reserved.
// R4 - First port format is ignored while the panel type selects an RGB panel.
// R5 - Second port width field holds pixels divided by two, minus one.
// R6 - Second port height field holds lines minus one.
// R7 - Software keeps width times height at forty pixels or more.
// R8 - Serial bit 5: 0 is four-wire 8-bit words, 1 is three-wire 9-bit words.
// R9 - Serial bit 4: 0 sends most significant bit first, 1 least significant first.
// R10 - Serial format 00 is 332 one transfer, 01 is 444 three per two.
// R11 - Serial phase and polarity choose data change edge and clock idle level.
// R12 - Sync enable set makes a started transfer begin at the next sync fall.
// R13 - A sync fall during a frame aborts that frame at that edge; the code aborts only while sync enable is set.
// R14 - The panel keeps the sync period longer than one frame transfer.
// R15 - Second port bit 6 picks bus style: 0 is 80-type, 1 is 68-type.
// R16 - Reserved bits 13 and 12 of the second port reset to zero.
// R17 - Software keeps sync enable set until the sync edge after a start.
// R18 - Unused bits read as zero and ignore writes.
`default_nettype none

package lcd_port_pkg;

   // Bus geometry
   localparam int ADDR_W = 10;
   localparam int REG_W = 16;

   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_P1_PAR = 8'h56;
   localparam logic [7:0] IDX_P2_WID = 8'h58;
   localparam logic [7:0] IDX_P2_HGT = 8'h5A;
   localparam logic [7:0] IDX_P2_SER = 8'h5C;
   localparam logic [7:0] IDX_P2_PAR = 8'h5E;
   localparam logic [7:0] IDX_STATUS = 8'h60;

   // Writable bits of each register
   localparam logic [15:0] MASK_P1_PAR = 16'h33C7;
   localparam logic [15:0] MASK_P2_PAR = 16'h30C7;
   localparam logic [15:0] MASK_WID = 16'h01FF;
   localparam logic [15:0] MASK_HGT = 16'h03FF;
   localparam logic [15:0] MASK_SER = 16'h003F;

   // Reset values
   localparam logic [15:0] RST_P1_PAR = 16'h0000;
   localparam logic [15:0] RST_WID = 16'h0000;
   localparam logic [15:0] RST_HGT = 16'h0000;
   localparam logic [15:0] RST_SER = 16'h0000;
   localparam logic [15:0] RST_P2_PAR = 16'h0000;

   // Field positions
   localparam int BIT_SYNC_EN = 7;
   localparam int BIT_TYPE68 = 6;
   localparam int FMT_LSB = 0;
   localparam int BIT_SER_3WIRE = 5;
   localparam int BIT_SER_LSB = 4;
   localparam int SER_FMT_LSB = 2;
   localparam int BIT_SER_PHASE = 1;
   localparam int BIT_SER_POL = 0;
   localparam int WID_W = 9;
   localparam int HGT_W = 10;

   // Status register bits
   localparam int ST_P1_BUSY = 0;
   localparam int ST_P2_BUSY = 1;
   localparam int ST_AREA_SMALL = 2;

   // Panel type codes that select an RGB panel
   localparam logic [1:0] PANEL_RGB_A = 2'h0;
   localparam logic [1:0] PANEL_RGB_B = 2'h1;

   // Smallest legal frame area in pixels
   localparam logic [21:0] MIN_AREA = 22'h000028;

   typedef enum logic [1:0] {
      GATE_IDLE = 2'b00,
      GATE_WAIT = 2'b01,
      GATE_SEND = 2'b10
   } gate_state_t;

   typedef struct packed {
      logic [4:0] bus_width;
      logic [1:0] cycles;
      logic [1:0] pixels;
      logic reserved;
   } fmt_info_t;

   // Parallel packing: bus width, cycles per group and pixels per group
   function automatic fmt_info_t decode_par_fmt(input logic [2:0] code);
      fmt_info_t f;
      f = '0;
      unique case (code)
         3'h0: f = '{5'h08, 2'h1, 2'h1, 1'b0};
         3'h1: f = '{5'h08, 2'h3, 2'h2, 1'b0};
         3'h2: f = '{5'h10, 2'h3, 2'h2, 1'b0};
         3'h3: f = '{5'h08, 2'h3, 2'h1, 1'b0};
         3'h4: f = '{5'h00, 2'h0, 2'h0, 1'b1};
         3'h5: f = '{5'h10, 2'h1, 2'h1, 1'b0};
         3'h6: f = '{5'h10, 2'h1, 2'h1, 1'b0};
         3'h7: f = '{5'h12, 2'h1, 2'h1, 1'b0};
      endcase
      return f;
   endfunction

   // Serial packing: 8-bit transfers for codes 0 and 1; codes 2 and 3 are reserved with zero width
   function automatic fmt_info_t decode_ser_fmt(input logic [1:0] code);
      fmt_info_t f;
      f = '0;
      unique case (code)
         2'h0: f = '{5'h08, 2'h1, 2'h1, 1'b0};
         2'h1: f = '{5'h08, 2'h3, 2'h2, 1'b0};
         2'h2: f = '{5'h00, 2'h0, 2'h0, 1'b1};
         2'h3: f = '{5'h00, 2'h0, 2'h0, 1'b1};
      endcase
      return f;
   endfunction

endpackage

`default_nettype wire

// >>> fsync_edge.sv
// Purpose: Bring a frame-sync pin into the system clock and flag its falling edges
// Assumes: Pin is asynchronous to the system clock
// Notes: Falling-edge pulse lags the pin by one to two cycles
`timescale 1ns/100ps
`default_nettype none

module fsync_edge (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Pin and edge
   input wire logic pin_in,
   output logic fall_out
);

   logic meta;
   logic stable;
   logic prev;

   // First flop feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= 1'b1;
         stable <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= pin_in;
         stable <= meta;
         prev <= stable;
      end
   end

   assign fall_out = prev & ~stable;

endmodule

`default_nettype wire

// >>> frame_gate.sv
// Purpose: Start, hold and abort frame output of one panel port against its frame sync
// Assumes: start and done are one-cycle pulses from logic on the same clock
// Notes: A start while busy is ignored
`timescale 1ns/100ps
`default_nettype none

module frame_gate
   import lcd_port_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic sync_en_in,
   input wire logic start_in,
   input wire logic done_in,
   input wire logic sync_fall_in,
   // Status
   output logic go_out,
   output logic abort_out,
   output logic busy_out
);

   gate_state_t state;
   gate_state_t next_state;
   logic next_go;
   logic next_abort;

   always_comb begin
      next_state = state;
      next_go = 1'b0;
      next_abort = 1'b0;
      unique case (state)
         GATE_IDLE: begin
            if (start_in && sync_en_in) begin
               next_state = GATE_WAIT; // R12
            end else if (start_in) begin
               next_state = GATE_SEND;
               next_go = 1'b1;
            end
         end
         GATE_WAIT: begin
            // Stays here until a sync edge even if the enable drops
            if (sync_fall_in) begin
               next_state = GATE_SEND; // R12 R17
               next_go = 1'b1;
            end
         end
         GATE_SEND: begin
            if (done_in) begin
               next_state = GATE_IDLE;
            end else if (sync_en_in && sync_fall_in) begin
               next_state = GATE_IDLE; // R13
               next_abort = 1'b1;
            end
         end
         default: next_state = GATE_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= GATE_IDLE;
         go_out <= 1'b0;
         abort_out <= 1'b0;
      end else begin
         state <= next_state;
         go_out <= next_go;
         abort_out <= next_abort;
      end
   end

   assign busy_out = (state != GATE_IDLE);

   a_go_at_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
      (state == GATE_WAIT && sync_fall_in) |=> go_out && state == GATE_SEND)
      else $error("transfer did not begin at sync fall");
   a_wait_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
      (state == GATE_WAIT && !sync_fall_in) |=> !go_out && state == GATE_WAIT)
      else $error("transfer began without sync fall");
   a_free_start: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
      (state == GATE_IDLE && start_in && !sync_en_in) |=> go_out ##1 !go_out && busy_out)
      else $error("unsynced start did not begin at once");
   a_abort_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
      (state == GATE_SEND && sync_en_in && sync_fall_in && !done_in) |=> abort_out && !busy_out)
      else $error("frame not aborted at sync fall");

endmodule

`default_nettype wire

// >>> panel_sync_model.sv
// Purpose: Panel-side source of the second port frame sync pin
// Assumes: Own 80 ns link clock, unrelated to the system clock
// Notes: Sync is low for two link cycles once every period_in+1 cycles
`timescale 1ns/100ps
`default_nettype none
module panel_sync_model (
   // Control
   input wire logic run_in,
   input wire logic [7:0] period_in,
   // Pin
   output logic sync_out
);
   logic lclk = 1'b0;
   logic [7:0] cnt = 8'h00;
   always #40 lclk = ~lclk;
   initial begin
      sync_out = 1'b1;
      forever begin
         @(posedge lclk);
         cnt <= (!run_in || cnt == period_in) ? 8'h00 : cnt + 8'h01;
         sync_out <= !run_in || cnt > 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> lcd_port_setup_tb.sv
// Purpose: Self-checking bench for the panel port setup block
// Assumes: APB slave may stretch the access phase; only the watchdog ends an APB wait
// Notes: Decoded outputs are checked three edges after a write
`timescale 1ns/100ps
`default_nettype none
module lcd_port_setup_tb;
   logic CLK_SYS_IN = 1'b0, RSTN_IN = 1'b0, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
   logic P1_START_IN = 1'b0, P1_DONE_IN = 1'b0, P2_START_IN = 1'b0, P2_DONE_IN = 1'b0;
   logic PORT1_FRAME_SYNC_IN = 1'b1, run = 1'b0;
   logic [7:0] per = 8'h28;
   logic [9:0] PADDR_IN = 10'h000;
   logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd;
   logic [3:0] PSTRB_IN = 4'hF;
   logic [1:0] PANEL_TYPE_IN = 2'h2, P1_CYCLES_OUT, P1_PIXELS_OUT, P2_CYCLES_OUT, P2_PIXELS_OUT;
   logic [1:0] P2_SER_XFERS_OUT, P2_SER_PIXELS_OUT;
   logic PREADY_OUT, PSLVERR_OUT, P1_GO_OUT, P1_ABORT_OUT, P1_BUSY_OUT, P2_GO_OUT, P2_ABORT_OUT;
   logic P2_BUSY_OUT, P1_TYPE68_OUT, P1_FMT_ACTIVE_OUT, P1_FMT_RSVD_OUT, P2_TYPE68_OUT, P2_FMT_RSVD_OUT;
   logic P2_AREA_SMALL_OUT, P2_SER_3WIRE_OUT, P2_SER_LSB_FIRST_OUT, P2_SER_RSVD_OUT, err;
   logic P2_SCLK_IDLE_HIGH_OUT, P2_SCLK_CHANGE_RISE_OUT;
   logic [4:0] P1_BUS_WIDTH_OUT, P2_BUS_WIDTH_OUT;
   logic [10:0] P2_WIDTH_PIX_OUT, P2_HEIGHT_OUT;
   logic [3:0] P2_SER_WORD_BITS_OUT;
   wire logic PORT2_FRAME_SYNC_IN;
   logic [8:0] h;
   logic [9:0] v;
   logic [9:0] addrs[5] = '{10'h158, 10'h160, 10'h168, 10'h170, 10'h178};
   logic [15:0] masks[5] = '{16'h33C7, 16'h01FF, 16'h03FF, 16'h003F, 16'h30C7};
   int errors = 0, comparisons = 0, seed = 72, n;
   lcd_port_setup dut (.*);
   panel_sync_model far (.run_in(run), .period_in(per), .sync_out(PORT2_FRAME_SYNC_IN));
   always #2 CLK_SYS_IN = ~CLK_SYS_IN;
   task finish_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_IN);
      PSEL_IN <= 1'b1;
      PENABLE_IN <= 1'b0;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      @(posedge CLK_SYS_IN);
      PENABLE_IN <= 1'b1;
      do begin
         @(posedge CLK_SYS_IN);
      end while (PREADY_OUT !== 1'b1);
      rd = PRDATA_OUT;
      err = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask
   task settle;
      repeat (3) @(posedge CLK_SYS_IN);
      @(negedge CLK_SYS_IN);
   endtask
   // One-cycle pulse on start or done of either port
   task pulse(input int k);
      @(posedge CLK_SYS_IN);
      {P2_DONE_IN, P2_START_IN, P1_DONE_IN, P1_START_IN} <= 4'h1 << k;
      @(posedge CLK_SYS_IN);
      {P2_DONE_IN, P2_START_IN, P1_DONE_IN, P1_START_IN} <= 4'h0;
      @(negedge CLK_SYS_IN);
   endtask
   // Bus width, cycles, pixels, reserved
   function automatic logic [9:0] pexp(input logic [2:0] c);
      case (c)
         3'h0: return {5'h08, 4'h5, 1'b0};
         3'h1: return {5'h08, 4'hE, 1'b0};
         3'h2: return {5'h10, 4'hE, 1'b0};
         3'h3: return {5'h08, 4'hD, 1'b0};
         3'h4: return 10'h001;
         3'h7: return {5'h12, 4'h5, 1'b0};
         default: return {5'h10, 4'h5, 1'b0};
      endcase
   endfunction
   function automatic logic [12:0] sexp(input logic [5:0] s);
      logic [4:0] f;
      f = (s[3:2] == 2'h0) ? 5'h0A : (s[3:2] == 2'h1) ? 5'h1C : 5'h01;
      return {s[5], s[5] ? 4'h9 : 4'h8, s[4], f, s[0], s[1] ^ s[0]};
   endfunction
   initial begin
      repeat (6) @(posedge CLK_SYS_IN);
      RSTN_IN <= 1'b1;
      settle;
      chk(P2_SER_WORD_BITS_OUT, 32'h8);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, addrs[i], 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, addrs[i], 32'hFFFFFFFF);
         apb(1'b0, addrs[i], 32'h0);
         chk(rd, masks[i]);
         chk(err, 32'h0);
      end
      apb(1'b1, 10'h200, 32'hFFFFFFFF);
      apb(1'b0, 10'h200, 32'h0);
      chk(rd, 32'h0);
      chk(err, 32'h1);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 10'h158, {25'h0, c[0], 3'h0, c[2:0]});
         apb(1'b1, 10'h178, {25'h0, c[0], 3'h0, c[2:0]});
         settle;
         chk({P2_BUS_WIDTH_OUT, P2_CYCLES_OUT, P2_PIXELS_OUT, P2_FMT_RSVD_OUT}, pexp(c[2:0]));
         chk({P1_BUS_WIDTH_OUT, P1_CYCLES_OUT, P1_PIXELS_OUT, P1_FMT_RSVD_OUT}, pexp(c[2:0]));
         chk({P1_TYPE68_OUT, P2_TYPE68_OUT}, {2{c[0]}});
      end
      for (int t = 2; t >= 0; t--) begin
         @(posedge CLK_SYS_IN);
         PANEL_TYPE_IN <= t[1:0];
         settle;
         chk(P1_FMT_ACTIVE_OUT, t == 2);
      end
      for (int s = 0; s < 64; s++) begin
         apb(1'b1, 10'h170, s);
         settle;
         chk({P2_SER_3WIRE_OUT, P2_SER_WORD_BITS_OUT, P2_SER_LSB_FIRST_OUT, P2_SER_XFERS_OUT,
              P2_SER_PIXELS_OUT, P2_SER_RSVD_OUT, P2_SCLK_IDLE_HIGH_OUT, P2_SCLK_CHANGE_RISE_OUT},
             sexp(s[5:0]));
      end
      for (int i = 0; i < 8; i++) begin
         h = (i == 0) ? 9'h013 : (i < 3) ? 9'(i - 1) : (i == 3) ? 9'h13F : 9'($random(seed));
         v = (i == 0) ? 10'h000 : (i < 3) ? 10'h009 : 10'($random(seed));
         apb(1'b1, 10'h160, {23'h0, h});
         apb(1'b1, 10'h168, {22'h0, v});
         settle;
         chk(P2_WIDTH_PIX_OUT, 32'(h) * 2 + 2);
         chk(P2_HEIGHT_OUT, 32'(v) + 1);
         n = (32'(h) + 1) * 2 * (32'(v) + 1) < 40;
         apb(1'b0, 10'h180, 32'h0);
         chk(rd, n << 2);
         chk(P2_AREA_SMALL_OUT, n);
      end
      apb(1'b1, 10'h158, 32'h80);
      pulse(0);
      chk({P1_ABORT_OUT, P1_GO_OUT, P1_BUSY_OUT}, 32'h3);
      pulse(1);
      chk(P1_BUSY_OUT, 32'h0);
      apb(1'b1, 10'h178, 32'h0);
      pulse(2);
      chk({P2_GO_OUT, P2_BUSY_OUT}, 32'h3);
      pulse(3);
      chk(P2_BUSY_OUT, 32'h0);
      apb(1'b1, 10'h178, 32'h80);
      pulse(2);
      chk({P2_GO_OUT, P2_BUSY_OUT}, 32'h1);
      run <= 1'b1;
      n = 0;
      while (P2_GO_OUT !== 1'b1 && n < 1000) begin
         @(negedge CLK_SYS_IN);
         n++;
      end
      chk(P2_GO_OUT, 32'h1);
      n = 0;
      while (P2_ABORT_OUT !== 1'b1 && n < 1000) begin
         @(negedge CLK_SYS_IN);
         n++;
      end
      chk(P2_ABORT_OUT, 32'h1);
      @(negedge CLK_SYS_IN);
      chk(P2_BUSY_OUT, 32'h0);
      finish_test;
   end
   initial begin
      #100000;
      errors++;
      finish_test;
   end
endmodule
`default_nettype wire
